// [tmt_timer.sv]
// Reload timer core with up/down counting, clock output and Wishbone registers
//
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
module tmt_timer
  import tmt_pkg::*;
#(
  parameter int PRE_DIV = PRESCALE
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic        count_pin_i,
  output logic             count_pin_o,
  output logic             count_pin_oe_o,
  input  wire logic        direction_pin_i,
  output logic             irq_o
);
  tmt_sync_if sy ();

  tmt_pin_sync u_sync (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .count_pin_i     (count_pin_i),
    .direction_pin_i (direction_pin_i),
    .sy              (sy)
  );

  logic [7:0]  timer_two_control_q;
  logic [1:0]  timer_two_mode_reg_q;
  logic [7:0]  reload_low_byte_q;
  logic [7:0]  reload_high_byte_q;
  logic [7:0]  count_low_byte_q;
  logic [7:0]  count_high_byte_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [7:0]  pre_q;
  logic        half_q;
  logic        clk_out_q;
  logic        ack_q;
  logic [31:0] dat_q;

  logic        wr;
  logic        rd;
  logic        tick;
  logic        up;
  logic        clkout;
  logic        baud;
  logic        wrap;
  logic [15:0] cnt;
  logic [15:0] rld;
  logic [15:0] cnt_d;
  tmt_mode_t   mode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  function automatic logic known(input logic [7:0] a);
    return hit(a, ADR_CTRL) | hit(a, ADR_MODE) | hit(a, ADR_RLL) | hit(a, ADR_RLH)
         | hit(a, ADR_CNTL) | hit(a, ADR_CNTH) | hit(a, ADR_IRQST) | hit(a, ADR_IRQMSK);
  endfunction : known

  // Write lands at the edge where the master samples ack
  assign wr  = cyc_i & stb_i & we_i & sel_i[0] & ack_q & known(adr_i);
  assign rd  = cyc_i & stb_i & ~ack_q;
  assign cnt = {count_high_byte_q, count_low_byte_q};
  assign rld = {reload_high_byte_q, reload_low_byte_q};

  // Mode decode from serial-clock selects and capture/reload select
  always_comb
  begin
    baud = timer_two_control_q[B_RCLK] | timer_two_control_q[B_TX_CLOCK_SELECT];
    if (baud)
      mode = TMT_BAUD;
    else if (timer_two_control_q[B_CPRL])
      mode = TMT_CAPTURE;
    else
      mode = TMT_RELOAD;
  end

  assign clkout = timer_two_mode_reg_q[B_OE] & ~timer_two_control_q[B_CSEL];

  // Source tick: divided clock, pin fall, or half rate for clock-out
  always_comb
  begin
    if (!timer_two_control_q[B_RUN])
      tick = 1'b0;
    else if (clkout || baud)
      tick = half_q;
    else if (timer_two_control_q[B_CSEL])
      tick = sy.cnt_fall;
    else
      tick = (pre_q == 8'(PRE_DIV - 1));
  end

  assign up = ~timer_two_mode_reg_q[B_DOWN_COUNT_ENABLE] | sy.dir_lvl | clkout | baud;

  always_comb
  begin
    cnt_d = cnt;
    wrap  = 1'b0;
    if (tick)
    begin
      if (up)
      begin
        if (cnt == CNT_MAX)
        begin
          wrap  = 1'b1;
          cnt_d = rld;
        end
        else
          cnt_d = cnt + 16'h0001;
      end
      else if (cnt == rld)
      begin
        wrap  = 1'b1;
        cnt_d = CNT_MAX;
      end
      else
        cnt_d = cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_q  <= BYTE_RST;
      half_q <= 1'b0;
    end
    else
    begin
      half_q <= ~half_q;
      if (pre_q == 8'(PRE_DIV - 1))
        pre_q <= BYTE_RST;
      else
        pre_q <= pre_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_low_byte_q  <= BYTE_RST;
      count_high_byte_q <= BYTE_RST;
    end
    else if (wr && hit(adr_i, ADR_CNTL))
      count_low_byte_q <= dat_i[7:0];
    else if (wr && hit(adr_i, ADR_CNTH))
      count_high_byte_q <= dat_i[7:0];
    else
    begin
      count_low_byte_q  <= cnt_d[7:0];
      count_high_byte_q <= cnt_d[15:8];
    end
  end

  // Clock output toggles on each overflow: period 4(65536-reload) clocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clk_out_q <= 1'b0;
    else if (!clkout)
      clk_out_q <= 1'b0;
    else if (wrap)
      clk_out_q <= ~clk_out_q;
  end

  assign count_pin_o    = clk_out_q;
  assign count_pin_oe_o = clkout;

  // Control register: hardware sets OVF, winning over a software write, and toggles EXF from the value written in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_two_control_q <= CTRL_RST;
    else
    begin
      if (wr && hit(adr_i, ADR_CTRL))
        timer_two_control_q <= dat_i[7:0];
      if (wrap && !baud && !clkout)
        timer_two_control_q[B_OVF] <= 1'b1;
      if (wrap && timer_two_mode_reg_q[B_DOWN_COUNT_ENABLE] && mode == TMT_RELOAD)
        timer_two_control_q[B_EXF] <= ~timer_two_control_q[B_EXF] ^
          (wr && hit(adr_i, ADR_CTRL) && dat_i[B_EXF] != timer_two_control_q[B_EXF]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_two_mode_reg_q <= 2'h0;
      reload_low_byte_q    <= BYTE_RST;
      reload_high_byte_q   <= BYTE_RST;
      irq_mask_q           <= 2'h0;
    end
    else if (wr)
    begin
      if (hit(adr_i, ADR_MODE))
        timer_two_mode_reg_q <= dat_i[1:0];
      if (hit(adr_i, ADR_RLL))
        reload_low_byte_q <= dat_i[7:0];
      if (hit(adr_i, ADR_RLH))
        reload_high_byte_q <= dat_i[7:0];
      if (hit(adr_i, ADR_IRQMSK))
        irq_mask_q <= dat_i[1:0];
    end
  end

  // Sticky interrupt status, write one to clear; new event wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_q <= 2'h0;
    else
    begin
      if (wr && hit(adr_i, ADR_IRQST))
        irq_stat_q <= irq_stat_q & ~dat_i[1:0];
      if (wrap && !baud && !clkout)
        irq_stat_q[IRQ_OVF] <= 1'b1;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= BUS_ZERO;
    end
    else
    begin
      ack_q <= rd & known(adr_i);
      dat_q <= BUS_ZERO;
      if (rd)
      begin
        case (1'b1)
          hit(adr_i, ADR_CTRL):   dat_q[7:0] <= timer_two_control_q;
          hit(adr_i, ADR_MODE):   dat_q[1:0] <= timer_two_mode_reg_q;
          hit(adr_i, ADR_RLL):    dat_q[7:0] <= reload_low_byte_q;
          hit(adr_i, ADR_RLH):    dat_q[7:0] <= reload_high_byte_q;
          hit(adr_i, ADR_CNTL):   dat_q[7:0] <= count_low_byte_q;
          hit(adr_i, ADR_CNTH):   dat_q[7:0] <= count_high_byte_q;
          hit(adr_i, ADR_IRQST):  dat_q[1:0] <= irq_stat_q;
          hit(adr_i, ADR_IRQMSK): dat_q[1:0] <= irq_mask_q;
          default:                dat_q      <= BUS_ZERO;
        endcase
      end
    end
  end

  logic err_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      err_q <= 1'b0;
    else
      err_q <= rd & ~known(adr_i) & ~err_q;
  end

  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = dat_q;
endmodule : tmt_timer

// [tmt_pkg.sv]
// Constants, register map and types for the reload timer with clock output
// How it works
// - Sixteen-bit count from two cascaded bytes
// - Select bit picks divide-by-12 clock or pin
// - Counting runs only while run bit set
// - Three modes from clock and reload selects
// - Down-count clear gives plain up reload timer
// - Direction pin high up, low down
// - Overflow at ffff sets flag, interrupts, reloads
// - Down match with reload sets flag, loads ffff
// - External flag toggles per reload-mode wrap with down-count set, no interrupt
// - Clock-out increments at half peripheral clock
// - Clock-out overflows reload, raise no interrupt
// - Output clock is fclk over 4(65536-reload)
// - Clock-out drives the count pin
// - Baud generation and clock-out share reload
// - Overflow flag set only with serial selects clear
// - Counter mode counts falling pin edges
package tmt_pkg;
  localparam logic [7:0] ADR_CTRL   = 8'hc8;
  localparam logic [7:0] ADR_MODE   = 8'hc9;
  localparam logic [7:0] ADR_RLL    = 8'hca;
  localparam logic [7:0] ADR_RLH    = 8'hcb;
  localparam logic [7:0] ADR_CNTL   = 8'hcc;
  localparam logic [7:0] ADR_CNTH   = 8'hcd;
  localparam logic [7:0] ADR_IRQST  = 8'hd0;
  localparam logic [7:0] ADR_IRQMSK = 8'hd4;
  localparam int B_OVF   = 7;
  localparam int B_EXF   = 6;
  localparam int B_RCLK  = 5;
  localparam int B_TX_CLOCK_SELECT  = 4;
  localparam int B_EXEN  = 3;
  localparam int B_RUN   = 2;
  localparam int B_CSEL  = 1;
  localparam int B_CPRL  = 0;
  localparam int B_OE    = 1;
  localparam int B_DOWN_COUNT_ENABLE  = 0;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_EXF = 1;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [31:0] BUS_ZERO  = 32'h0000_0000;
  localparam int          PRESCALE  = 12;
  localparam int          HALF_DIV  = 2;
  typedef enum logic [2:0] {
    TMT_CAPTURE = 3'b001,
    TMT_RELOAD  = 3'b010,
    TMT_BAUD    = 3'b100
  } tmt_mode_t;
endpackage : tmt_pkg

// [tmt_sync_if.sv]
// Synchronised pin samples passed from the pin stage to the timer core
`timescale 1ns/10ps
interface tmt_sync_if;
  logic cnt_fall;
  logic dir_lvl;
  modport src (output cnt_fall, output dir_lvl);
  modport dst (input cnt_fall, input dir_lvl);
endinterface : tmt_sync_if

// [tmt_pin_sync.sv]
// Three-stage pin synchroniser with falling-edge detect
`timescale 1ns/10ps
module tmt_pin_sync
  import tmt_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic count_pin_i,
  input  wire logic direction_pin_i,
  tmt_sync_if.src   sy
);
  logic [2:0] cnt_q;
  logic [2:0] dir_q;
  logic       cnt_lvl_q;
  logic       dir_lvl_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 3'h7;
      dir_q <= 3'h7;
    end
    else
    begin
      cnt_q <= {cnt_q[1:0], count_pin_i};
      dir_q <= {dir_q[1:0], direction_pin_i};
    end
  end

  // A level counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_lvl_q <= 1'b1;
      dir_lvl_q <= 1'b1;
    end
    else
    begin
      if (cnt_q[1] == cnt_q[2])
        cnt_lvl_q <= cnt_q[2];
      if (dir_q[1] == dir_q[2])
        dir_lvl_q <= dir_q[2];
    end
  end

  assign sy.cnt_fall = cnt_lvl_q & ~cnt_q[2] & ~cnt_q[1];
  assign sy.dir_lvl  = dir_lvl_q;
endmodule : tmt_pin_sync

// [tmt_timer_chk.sv]
// Bus and clock-out checker for the reload timer
`timescale 1ns/10ps
module tmt_timer_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        count_pin_o,
  input wire logic        count_pin_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  err_pulse_a: assert property (err_o |=> !err_o)
    else $error("err too long");
  resp_cause_a: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
    else $error("answer without request");
  resp_excl_a: assert property (!(ack_o && err_o))
    else $error("ack with err");
  req_answer_a: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("request not answered");
  rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  oe_cause_a: assert property ($changed(count_pin_oe_o) |-> $past(cyc_i && stb_i && we_i))
    else $error("pin enable moved without write");
  clk_half_a: assert property (count_pin_oe_o && $changed(count_pin_o) |=> $stable(count_pin_o))
    else $error("clock out half period short");
endmodule : tmt_timer_chk

bind tmt_timer tmt_timer_chk tmt_timer_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o,
  .ack_o, .err_o, .count_pin_o, .count_pin_oe_o);

// [tmt_pins_model.sv]
// Far-side pins: pulse source on the count pin and direction level
`timescale 1ns/10ps
module tmt_pins_model #(
  parameter int HALF = 4
)
(
  input  wire logic clk_i,
  input  wire logic pulse_en_i,
  input  wire logic dir_up_i,
  input  wire logic pin_drv_i,
  input  wire logic pin_oe_i,
  output logic      count_pin_o,
  output logic      direction_pin_o
);
  int   cnt_q = 0;
  logic lvl_q = 1'b1;
  always @(posedge clk_i)
  begin
    if (!pulse_en_i)
    begin
      cnt_q <= 0;
      lvl_q <= 1'b1;
    end
    else if (cnt_q == HALF - 1)
    begin
      cnt_q <= 0;
      lvl_q <= !lvl_q;
    end
    else
      cnt_q <= cnt_q + 1;
  end
  // Pulse source level (high while pulses are off) unless the timer drives its generated clock
  assign count_pin_o     = pin_oe_i ? pin_drv_i : lvl_q;
  assign direction_pin_o = dir_up_i;
endmodule : tmt_pins_model

// [tmt_timer_tb_top.sv]
// Testbench for the reload timer
`timescale 1ns/10ps
module tmt_timer_tb_top
  import tmt_pkg::*;
();
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        ack, err, pin_o, oe, irq, pin_i, dir_i, qe;
  logic        pulse_en = 1'b0;
  logic        dir_up = 1'b1;
  logic [7:0]  q;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cyc_n = 0;
  int          t0;
  tmt_timer tmt_timer_i (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wd), .dat_o(rdat), .ack_o(ack), .err_o(err), .count_pin_i(pin_i),
    .count_pin_o(pin_o), .count_pin_oe_o(oe), .direction_pin_i(dir_i), .irq_o(irq));
  tmt_pins_model tmt_pins_model_i (.clk_i, .pulse_en_i(pulse_en), .dir_up_i(dir_up),
    .pin_drv_i(pin_o), .pin_oe_i(oe), .count_pin_o(pin_i), .direction_pin_o(dir_i));
  initial forever #4 clk_i = ~clk_i;
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 5000)
    begin
      n_mismatch++;
      end_sim;
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= {24'h000000, d};
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    q = rdat[7:0];
    qe = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00);
    chk(n, e, q);
  endtask : rdc
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(ADR_CTRL, CTRL_RST, "ctrl");
    bus(1'b0, 8'h80, 8'h00);
    chk("unmapped", 8'h01, {7'h00, qe});
    wr(ADR_CNTL, 8'h00);
    wr(ADR_CNTH, 8'h00);
    wr(ADR_CTRL, 8'h06);
    pulse_en <= 1'b1;
    repeat (40) @(posedge clk_i);
    pulse_en <= 1'b0;
    repeat (10) @(posedge clk_i);
    wr(ADR_CTRL, 8'h02);
    rdc(ADR_CNTL, 8'h05, "falls");
    pulse_en <= 1'b1;
    repeat (16) @(posedge clk_i);
    pulse_en <= 1'b0;
    repeat (10) @(posedge clk_i);
    rdc(ADR_CNTL, 8'h05, "halted");
    wr(ADR_RLL, 8'h34);
    wr(ADR_RLH, 8'h12);
    wr(ADR_CNTL, 8'hfe);
    wr(ADR_CNTH, 8'hff);
    wr(ADR_IRQMSK, 8'h01);
    wr(ADR_CTRL, 8'h04);
    for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk_i);
    chk("irq", 8'h01, {7'h00, irq});
    rdc(ADR_CTRL, 8'h84, "ovf");
    wr(ADR_CTRL, 8'h80);
    rdc(ADR_CNTH, 8'h12, "reload");
    wr(ADR_IRQST, 8'h01);
    chk("irq off", 8'h00, {7'h00, irq});
    rdc(ADR_CTRL, 8'h80, "sticky");
    wr(ADR_CTRL, 8'h00);
    wr(ADR_MODE, 8'h01);
    dir_up <= 1'b0;
    wr(ADR_RLL, 8'h10);
    wr(ADR_RLH, 8'h00);
    wr(ADR_CNTL, 8'h11);
    wr(ADR_CNTH, 8'h00);
    wr(ADR_CTRL, 8'h04);
    repeat (60) @(posedge clk_i);
    rdc(ADR_CTRL, 8'hc4, "down flags");
    wr(ADR_CTRL, 8'h00);
    rdc(ADR_CNTH, 8'hff, "down wrap");
    chk("irq on", 8'h01, {7'h00, irq});
    wr(ADR_IRQMSK, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq});
    rdc(ADR_IRQST, 8'h01, "stat kept");
    dir_up <= 1'b1;
    wr(ADR_CNTL, 8'hfe);
    wr(ADR_CNTH, 8'hff);
    wr(ADR_CTRL, 8'h04);
    repeat (60) @(posedge clk_i);
    rdc(ADR_CTRL, 8'hc4, "up flags");
    wr(ADR_CTRL, 8'h00);
    rdc(ADR_CNTH, 8'h00, "up reload");
    wr(ADR_MODE, 8'h02);
    wr(ADR_IRQST, 8'h01);
    wr(ADR_RLL, 8'hfe);
    wr(ADR_RLH, 8'hff);
    wr(ADR_CNTL, 8'hfe);
    wr(ADR_CNTH, 8'hff);
    for (int k = 0; k < 2; k++)
    begin
      wr(ADR_CTRL, k ? 8'h14 : 8'h04);
      chk("pin oe", 8'h01, {7'h00, oe});
      @(posedge pin_o);
      t0 = cyc_n;
      @(posedge pin_o);
      chk("period", 8'h08, 8'(cyc_n - t0));
      @(posedge clk_i);
      rdc(ADR_CTRL, k ? 8'h14 : 8'h04, "no flag");
    end
    rdc(ADR_IRQST, 8'h00, "no irq");
    wr(ADR_CTRL, 8'h00);
    end_sim;
  end
endmodule : tmt_timer_tb_top
